/* File: hw/ppa_port_ctrl.sv */
// Eight-port operating mode, classification and power allocation controller
`timescale 1ns/1ps
module ppa_port_ctrl #(
    parameter int unsigned FINGER_CYC = ppa_pkg::FINGER_CYC,
    parameter int unsigned MPS_CYC    = ppa_pkg::MPS_CYC
) (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        ce_i,
    // Register access
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    // Measurement front end
    output logic      [7:0]  det_start_o,
    input  wire logic [7:0]  det_done_i,
    input  wire logic [7:0]  det_valid_i,
    output logic      [7:0]  cls_start_o,
    input  wire logic [7:0]  cls_done_i,
    input  wire logic [31:0] cls_value_i,
    // Port power
    output logic      [7:0]  power_on_o,
    output logic      [15:0] fingers_o,
    output logic      [7:0]  port_reset_o,
    input  wire logic [7:0]  fault_i,
    input  wire logic [7:0]  mps_ok_i,
    output logic      [31:0] policing_o
);
    import ppa_pkg::*;
    ppa_state_type         st_reg    [NPORT];
    logic [TMR_W-1:0]      tmr_reg   [NPORT];
    logic [1:0]            mode_reg  [NPORT];
    logic [1:0]            alloc_reg [NPORT];
    logic [3:0]            req_reg   [NPORT];
    logic [3:0]            asg_reg   [NPORT];
    logic [7:0]            police_reg[4];
    logic [7:0]            det_res_reg;
    logic [7:0]            insuff_reg;
    logic [7:0]            sflt_reg;
    logic [7:0]            pen_cmd;
    logic [7:0]            det_cmd;
    logic [7:0]            cls_cmd;
    logic [7:0]            sf_set;
    logic [7:0]            rd_next;
    localparam logic [TMR_W-1:0] FING_LAST = TMR_W'(FINGER_CYC - 1);
    localparam logic [TMR_W-1:0] MPS_LAST  = TMR_W'(MPS_CYC - 1);
    // Class that the port is granted under an allocation; demoted to 3 or 4 where it exceeds a 15 W or 30 W allocation
    function automatic logic [3:0] grant_class(input logic [3:0] req, input logic [1:0] alloc);
        grant_class = req;
        if (alloc == ALLOC_15W && req > 4'h3) begin
            grant_class = 4'h3;
        end else if (alloc == ALLOC_30W && req > 4'h4) begin
            grant_class = 4'h4;
        end
    endfunction
    // A 4 W allocation takes classes 0 and 1, 7 W classes 0 to 2
    function automatic logic short_power(input logic [3:0] req, input logic [1:0] alloc);
        short_power = (alloc == ALLOC_4W && req > 4'h1) || (alloc == ALLOC_7W && req > 4'h2);
    endfunction
    function automatic logic [1:0] finger_count(input logic [3:0] cls);
        finger_count = (cls >= 4'h4) ? FING_THREE : FING_ONE;
    endfunction
    function automatic logic [7:0] pack_pair(input logic [3:0] lo, input logic [3:0] hi);
        pack_pair = {hi, lo};
    endfunction
    always_comb begin
        for (int i = 0; i < NPORT; i++) begin
            pen_cmd[i] = reg_wr_i && reg_addr_i == A_PWR_EN && reg_wdata_i[i];
            det_cmd[i] = reg_wr_i && reg_addr_i == A_DET_CMD && reg_wdata_i[i];
            cls_cmd[i] = reg_wr_i && reg_addr_i == A_CLS_CMD && reg_wdata_i[i];
            sf_set[i]  = st_reg[i] == ST_CLS && cls_done_i[i] && mode_reg[i] != MODE_MAN
                         && mode_reg[i] != MODE_OFF && short_power(cls_value_i[4*i+:4], alloc_reg[i]);
        end
    end
    // Host-written configuration
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < NPORT; i++) begin
                mode_reg[i]  <= MODE_RST;
                alloc_reg[i] <= ALLOC_RST;
            end
            for (int k = 0; k < 4; k++) begin
                police_reg[k] <= POLICE_RST;
            end
        end else if (ce_i && reg_wr_i) begin
            for (int k = 0; k < 4; k++) begin
                if (reg_addr_i == A_MODE_LO) begin
                    mode_reg[k] <= reg_wdata_i[2*k+:2];
                end
                if (reg_addr_i == A_MODE_HI) begin
                    mode_reg[k+4] <= reg_wdata_i[2*k+:2];
                end
                if (reg_addr_i == A_ALLOC_LO) begin
                    alloc_reg[k] <= reg_wdata_i[2*k+:2];
                end
                if (reg_addr_i == A_ALLOC_HI) begin
                    alloc_reg[k+4] <= reg_wdata_i[2*k+:2];
                end
                if (reg_addr_i == A_POLICE + 8'(k)) begin
                    police_reg[k] <= reg_wdata_i;
                end
            end
        end
    end
    // Power limit comes only from the policing bytes, never from the allocation
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            policing_o <= {4{POLICE_RST}};
        end else if (ce_i) begin
            policing_o <= {police_reg[3], police_reg[2], police_reg[1], police_reg[0]};
        end
    end
    // Sticky fault flags clear on read; a set in the same cycle wins
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            insuff_reg <= 8'h00;
            sflt_reg   <= 8'h00;
        end else if (ce_i) begin
            insuff_reg <= ((reg_rd_i && reg_addr_i == A_INSUFF) ? 8'h00 : insuff_reg) | sf_set;
            sflt_reg   <= ((reg_rd_i && reg_addr_i == A_SFLT) ? 8'h00 : sflt_reg) | sf_set;
        end
    end
    // Per-port sequencer
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < NPORT; i++) begin
                st_reg[i]  <= ST_IDLE;
                tmr_reg[i] <= '0;
                req_reg[i] <= 4'h0;
                asg_reg[i] <= 4'h0;
            end
            det_res_reg  <= 8'h00;
            det_start_o  <= 8'h00;
            cls_start_o  <= 8'h00;
            power_on_o   <= 8'h00;
            port_reset_o <= 8'h00;
            fingers_o    <= 16'h0000;
        end else if (ce_i) begin
            for (int i = 0; i < NPORT; i++) begin
                det_start_o[i]  <= 1'b0;
                cls_start_o[i]  <= 1'b0;
                port_reset_o[i] <= 1'b0;
                if (mode_reg[i] == MODE_OFF) begin
                    st_reg[i]         <= ST_IDLE;
                    power_on_o[i]     <= 1'b0;
                    fingers_o[2*i+:2] <= 2'h0;
                    det_res_reg[i]    <= 1'b0;
                    asg_reg[i]        <= 4'h0;
                end else begin
                    unique case (st_reg[i])
                        ST_IDLE: begin
                            if (mode_reg[i] != MODE_MAN) begin
                                det_start_o[i] <= 1'b1;
                                st_reg[i]      <= ST_DET;
                            end else if (pen_cmd[i]) begin
                                power_on_o[i] <= 1'b1;
                                asg_reg[i]    <= 4'h0;
                                tmr_reg[i]    <= '0;
                                st_reg[i]     <= ST_ON;
                            end else if (det_cmd[i]) begin
                                det_start_o[i] <= 1'b1;
                                st_reg[i]      <= ST_DET;
                            end else if (cls_cmd[i]) begin
                                cls_start_o[i] <= 1'b1;
                                st_reg[i]      <= ST_CLS;
                            end
                        end
                        ST_DET: begin
                            if (det_done_i[i]) begin
                                det_res_reg[i] <= det_valid_i[i];
                                if (mode_reg[i] != MODE_MAN && det_valid_i[i]) begin
                                    cls_start_o[i] <= 1'b1;
                                    st_reg[i]      <= ST_CLS;
                                end else begin
                                    st_reg[i] <= ST_IDLE;
                                end
                            end
                        end
                        ST_CLS: begin
                            if (cls_done_i[i]) begin
                                req_reg[i] <= cls_value_i[4*i+:4];
                                if (mode_reg[i] == MODE_MAN) begin
                                    port_reset_o[i] <= 1'b1;
                                    st_reg[i]       <= ST_IDLE;
                                end else if (sf_set[i]) begin
                                    st_reg[i] <= ST_IDLE;
                                end else begin
                                    fingers_o[2*i+:2] <= finger_count(grant_class(cls_value_i[4*i+:4],
                                                                                  alloc_reg[i]));
                                    tmr_reg[i]        <= '0;
                                    st_reg[i]         <= ST_HOLD;
                                end
                            end
                        end
                        ST_HOLD: begin
                            if (tmr_reg[i] == FING_LAST) begin
                                if (mode_reg[i] == MODE_AUTO) begin
                                    power_on_o[i] <= 1'b1;
                                    asg_reg[i]    <= grant_class(req_reg[i], alloc_reg[i]);
                                    tmr_reg[i]    <= '0;
                                    st_reg[i]     <= ST_ON;
                                end else begin
                                    st_reg[i] <= ST_WAIT;
                                end
                            end else begin
                                tmr_reg[i] <= tmr_reg[i] + 1'b1;
                            end
                        end
                        ST_WAIT: begin
                            if (mode_reg[i] == MODE_MAN) begin
                                fingers_o[2*i+:2] <= 2'h0;
                                st_reg[i]         <= ST_IDLE;
                            end else if (pen_cmd[i] || mode_reg[i] == MODE_AUTO) begin
                                power_on_o[i] <= 1'b1;
                                asg_reg[i]    <= grant_class(req_reg[i], alloc_reg[i]);
                                tmr_reg[i]    <= '0;
                                st_reg[i]     <= ST_ON;
                            end
                        end
                        ST_ON: begin
                            if (fault_i[i] || (!mps_ok_i[i] && tmr_reg[i] == MPS_LAST)) begin
                                power_on_o[i]     <= 1'b0;
                                fingers_o[2*i+:2] <= 2'h0;
                                st_reg[i]         <= ST_IDLE;
                            end else begin
                                tmr_reg[i] <= mps_ok_i[i] ? '0 : tmr_reg[i] + 1'b1;
                            end
                        end
                    endcase
                end
            end
        end
    end
    // Read data is registered: it appears the cycle after the read strobe
    always_comb begin
        rd_next = 8'h00;
        if (reg_addr_i[7:2] == A_REQ_CLS[7:2]) begin
            rd_next = pack_pair(req_reg[2*reg_addr_i[1:0]], req_reg[2*reg_addr_i[1:0]+1]);
        end else if (reg_addr_i[7:2] == A_ASG_CLS[7:2]) begin
            rd_next = pack_pair(asg_reg[2*reg_addr_i[1:0]], asg_reg[2*reg_addr_i[1:0]+1]);
        end else if (reg_addr_i >= A_POLICE && reg_addr_i <= A_POLICE + 8'h03) begin
            rd_next = police_reg[2'(reg_addr_i - A_POLICE)];
        end else begin
            unique case (reg_addr_i)
                A_DET_RES:  rd_next = det_res_reg;
                A_PWR_STS:  rd_next = power_on_o;
                A_SFLT:     rd_next = sflt_reg;
                A_INSUFF:   rd_next = insuff_reg;
                A_MODE_LO:  rd_next = {mode_reg[3], mode_reg[2], mode_reg[1], mode_reg[0]};
                A_MODE_HI:  rd_next = {mode_reg[7], mode_reg[6], mode_reg[5], mode_reg[4]};
                A_ALLOC_LO: rd_next = {alloc_reg[3], alloc_reg[2], alloc_reg[1], alloc_reg[0]};
                A_ALLOC_HI: rd_next = {alloc_reg[7], alloc_reg[6], alloc_reg[5], alloc_reg[4]};
                default:    rd_next = 8'h00;
            endcase
        end
    end
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (ce_i && reg_rd_i) begin
            reg_rdata_o <= rd_next;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    // Every port is watched, so each mode is checked on whichever port runs it
    for (genvar p = 0; p < NPORT; p++) begin : g_port_chk
        property p_off_clears;
            ce_i && mode_reg[p] == MODE_OFF |=> !power_on_o[p] && !det_start_o[p] && !det_res_reg[p];
        endproperty
        a_off_clears: assert property (p_off_clears) else $error("off port still active");
        property p_semi_needs_enable;
            ce_i && st_reg[p] == ST_WAIT && mode_reg[p] == MODE_SEMI && !pen_cmd[p] |=> !power_on_o[p];
        endproperty
        a_semi_needs_enable: assert property (p_semi_needs_enable) else $error("semi port self powered");
        property p_man_enable;
            ce_i && st_reg[p] == ST_IDLE && mode_reg[p] == MODE_MAN && pen_cmd[p]
            |=> power_on_o[p] && asg_reg[p] == 4'h0;
        endproperty
        a_man_enable: assert property (p_man_enable) else $error("manual enable failed");
        property p_man_quiet;
            ce_i && st_reg[p] == ST_IDLE && mode_reg[p] == MODE_MAN && !det_cmd[p] && !cls_cmd[p]
            |=> !det_start_o[p] && !cls_start_o[p];
        endproperty
        a_man_quiet: assert property (p_man_quiet) else $error("manual port measured unasked");
        property p_cls_after_valid;
            cls_start_o[p] && $past(mode_reg[p]) != MODE_MAN |-> $past(det_done_i[p] && det_valid_i[p]);
        endproperty
        a_cls_after_valid: assert property (p_cls_after_valid) else $error("class without valid detection");
        property p_man_reset;
            ce_i && st_reg[p] == ST_CLS && cls_done_i[p] && mode_reg[p] == MODE_MAN
            |=> port_reset_o[p] ##1 !port_reset_o[p];
        endproperty
        a_man_reset: assert property (p_man_reset) else $error("no port reset after manual class");
        property p_short_power;
            ce_i && sf_set[p] |=> insuff_reg[p] && sflt_reg[p] && !power_on_o[p] && st_reg[p] == ST_IDLE;
        endproperty
        a_short_power: assert property (p_short_power) else $error("insufficient power not flagged");
        property p_fault_off;
            ce_i && power_on_o[p] && fault_i[p] && mode_reg[p] != MODE_OFF |=> !power_on_o[p] ##1 !power_on_o[p];
        endproperty
        a_fault_off: assert property (p_fault_off) else $error("port kept power on fault");
        property p_auto_on_class;
            $rose(power_on_o[p]) && $past(st_reg[p]) == ST_HOLD
            |-> asg_reg[p] == grant_class($past(req_reg[p]), $past(alloc_reg[p]))
                && $past(tmr_reg[p]) == FING_LAST;
        endproperty
        a_auto_on_class: assert property (p_auto_on_class) else $error("auto turn-on class or timing wrong");
        c_auto_on: cover property ($rose(power_on_o[p]) && mode_reg[p] == MODE_AUTO);
        c_semi_on: cover property ($rose(power_on_o[p]) && mode_reg[p] == MODE_SEMI);
        c_insuff:  cover property (sf_set[p]);
        c_mps_off: cover property ($fell(power_on_o[p]) && !$past(fault_i[p]));
    end
endmodule

/* File: hw/ppa_pkg.sv */
// Constants, register map and state encoding for the port mode and power allocation block
package ppa_pkg;
    localparam int unsigned NPORT      = 8;
    localparam int unsigned CLK_MHZ    = 200;
    localparam int unsigned FINGER_MS  = 100;
    localparam int unsigned MPS_MS     = 6;
    localparam int unsigned FINGER_CYC = FINGER_MS * CLK_MHZ * 1000;
    localparam int unsigned MPS_CYC    = MPS_MS * CLK_MHZ * 1000;
    localparam int unsigned TMR_W      = 25;

    localparam logic [7:0] A_DET_RES  = 8'h08;
    localparam logic [7:0] A_REQ_CLS  = 8'h0C;
    localparam logic [7:0] A_PWR_STS  = 8'h10;
    localparam logic [7:0] A_SFLT     = 8'h11;
    localparam logic [7:0] A_MODE_LO  = 8'h12;
    localparam logic [7:0] A_MODE_HI  = 8'h13;
    localparam logic [7:0] A_DET_CMD  = 8'h14;
    localparam logic [7:0] A_CLS_CMD  = 8'h15;
    localparam logic [7:0] A_PWR_EN   = 8'h19;
    localparam logic [7:0] A_POLICE   = 8'h1E;
    localparam logic [7:0] A_INSUFF   = 8'h24;
    localparam logic [7:0] A_ALLOC_LO = 8'h29;
    localparam logic [7:0] A_ALLOC_HI = 8'h2A;
    localparam logic [7:0] A_ASG_CLS  = 8'h4C;

    localparam logic [1:0] MODE_OFF  = 2'h0;
    localparam logic [1:0] MODE_MAN  = 2'h1;
    localparam logic [1:0] MODE_SEMI = 2'h2;
    localparam logic [1:0] MODE_AUTO = 2'h3;

    localparam logic [1:0] ALLOC_4W  = 2'h0;
    localparam logic [1:0] ALLOC_7W  = 2'h1;
    localparam logic [1:0] ALLOC_15W = 2'h2;
    localparam logic [1:0] ALLOC_30W = 2'h3;

    localparam logic [1:0] MODE_RST   = MODE_OFF;
    localparam logic [1:0] ALLOC_RST  = ALLOC_30W;
    localparam logic [7:0] POLICE_RST = 8'h00;
    localparam logic [1:0] FING_ONE   = 2'h1;
    localparam logic [1:0] FING_THREE = 2'h3;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_DET  = 6'b000010,
        ST_CLS  = 6'b000100,
        ST_HOLD = 6'b001000,
        ST_WAIT = 6'b010000,
        ST_ON   = 6'b100000
    } ppa_state_type;
endpackage

/* File: tb/ppa_pd_model.sv */
// Measurement front end model answering detection and classification starts
`timescale 1ns/1ps
module ppa_pd_model #(
    parameter int unsigned DLY = 3
) (
    input  wire logic        ref_clk_i,
    input  wire logic [7:0]  det_start_i,
    input  wire logic [7:0]  cls_start_i,
    input  wire logic [7:0]  det_ok_i,
    input  wire logic [31:0] cls_cfg_i,
    output logic      [7:0]  det_done_o,
    output logic      [7:0]  det_valid_o,
    output logic      [7:0]  cls_done_o,
    output logic      [31:0] cls_value_o
);
    logic [7:0] det_sr [DLY];
    logic [7:0] cls_sr [DLY];
    logic       tgl = 1'b0;
    always_ff @(posedge ref_clk_i) begin
        tgl       <= ~tgl;
        det_sr[0] <= det_start_i;
        cls_sr[0] <= cls_start_i;
        for (int k = 1; k < DLY; k++) begin
            det_sr[k] <= det_sr[k-1];
            cls_sr[k] <= cls_sr[k-1];
        end
    end
    assign det_done_o = det_sr[DLY-1];
    assign cls_done_o = cls_sr[DLY-1];
    // Qualifiers toggle outside a done pulse so a stale value is never trusted
    for (genvar p = 0; p < 8; p++) begin : g_port
        assign det_valid_o[p]     = det_done_o[p] ? det_ok_i[p] : tgl;
        assign cls_value_o[4*p+:4] = cls_done_o[p] ? cls_cfg_i[4*p+:4] : {4{tgl}};
    end
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the port mode and power allocation controller
`timescale 1ns/1ps
module tb;
    import ppa_pkg::*;
    logic        ref_clk_i = 1'b0;
    logic        arst_n_i  = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [7:0]  reg_wdata_i = 8'h00;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [7:0]  fault_i = 8'h00;
    logic [7:0]  mps_ok_i = 8'hFF;
    logic [7:0]  det_ok = 8'hFF;
    logic [31:0] cls_cfg = 32'h0000_0210;
    logic [7:0]  reg_rdata_o, det_start_o, det_done_i, det_valid_i, cls_start_o, cls_done_i;
    logic [7:0]  power_on_o, port_reset_o, mode_lo, d, n1, n2, n3, c3;
    logic [15:0] fingers_o;
    logic [31:0] cls_value_i, policing_o;
    int          bad_count = 0;
    int          n_checks = 0;
    logic        ce_i = 1'b1;
    localparam int FING_TB = 16;
    localparam int MPS_TB  = 8;
    always #2.5 ref_clk_i = ~ref_clk_i;
    ppa_port_ctrl #(.FINGER_CYC(FING_TB), .MPS_CYC(MPS_TB)) uut (.ref_clk_i, .arst_n_i, .ce_i, .reg_addr_i,
        .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .det_start_o, .det_done_i, .det_valid_i,
        .cls_start_o, .cls_done_i, .cls_value_i, .power_on_o, .fingers_o, .port_reset_o, .fault_i,
        .mps_ok_i, .policing_o);
    ppa_pd_model pd (.ref_clk_i, .det_start_i(det_start_o), .cls_start_i(cls_start_o), .det_ok_i(det_ok),
        .cls_cfg_i(cls_cfg), .det_done_o(det_done_i), .det_valid_o(det_valid_i), .cls_done_o(cls_done_i),
        .cls_value_o(cls_value_i));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge ref_clk_i);
        {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, v, 1'b1};
        @(negedge ref_clk_i);
        reg_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge ref_clk_i);
        {reg_addr_i, reg_rd_i} = {a, 1'b1};
        @(negedge ref_clk_i);
        reg_rd_i = 1'b0;
        v = reg_rdata_o;
    endtask
    // Outcome on port 0 for one allocation and one requested class
    task automatic alloc_case(input logic [1:0] a, input logic [3:0] c);
        logic [3:0] cap, asg;
        logic [1:0] fmax;
        logic [7:0] hold;
        cap = {2'h0, a} + 4'h1;
        asg = (c <= cap) ? c : (a >= ALLOC_15W) ? cap : 4'h0;
        fmax = 2'h0;
        hold = 8'h00;
        cls_cfg[3:0] = c;
        wr(A_ALLOC_LO, {6'h3F, a});
        wr(A_MODE_LO, 8'h03);
        repeat (60) begin
            @(negedge ref_clk_i);
            if (fingers_o[1:0] > fmax) fmax = fingers_o[1:0];
            if (fingers_o[1:0] != 2'h0 && !power_on_o[0]) hold = hold + 8'h01;
        end
        chk("power", {7'h0, power_on_o[0]}, {7'h0, asg != 4'h0});
        chk("fingers", {6'h0, fmax}, asg == 4'h0 ? 8'h00 : asg >= 4'h4 ? 8'h03 : 8'h01);
        chk("finger_hold", hold, asg == 4'h0 ? 8'h00 : 8'(FING_TB));
        rd(A_INSUFF, d); chk("insuff", {7'h0, d[0]}, {7'h0, asg == 4'h0});
        rd(A_SFLT, d); chk("start_fault", {7'h0, d[0]}, {7'h0, asg == 4'h0});
        rd(A_REQ_CLS, d); chk("req_cls", {4'h0, d[3:0]}, {4'h0, c});
        rd(A_ASG_CLS, d); chk("asg_cls", {4'h0, d[3:0]}, {4'h0, asg});
        wr(A_MODE_LO, 8'h00);
        // The sequencer sees the new mode one edge after the write lands
        @(negedge ref_clk_i);
        chk("off_power", {7'h0, power_on_o[0]}, 8'h00);
        rd(A_INSUFF, d);
        rd(A_SFLT, d);
    endtask
    initial begin
        repeat (12) @(negedge ref_clk_i);
        arst_n_i = 1'b1;
        rd(A_ALLOC_LO, d); chk("alloc_rst", d, {4{ALLOC_RST}});
        rd(A_MODE_LO, d); chk("mode_rst", d, {4{MODE_RST}});
        rd(8'h7F, d); chk("unmapped", d, 8'h00);
        $display("test reset done");
        alloc_case(ALLOC_4W, 4'h1);
        alloc_case(ALLOC_4W, 4'h2);
        alloc_case(ALLOC_7W, 4'h2);
        alloc_case(ALLOC_7W, 4'h3);
        alloc_case(ALLOC_15W, 4'h5);
        alloc_case(ALLOC_30W, 4'h5);
        alloc_case(ALLOC_30W, 4'h4);
        $display("test allocation done");
        // Port 1 semi, port 2 manual, port 3 auto with a failing detection
        {det_ok, n1, n2, n3, c3} = {8'hF7, 32'h0};
        mode_lo = 8'hD8;
        wr(A_MODE_LO, mode_lo);
        repeat (60) begin
            @(negedge ref_clk_i);
            {n1, n2} = {n1 + {7'h0, det_start_o[1]}, n2 + {7'h0, det_start_o[2] | cls_start_o[2]}};
            {n3, c3} = {n3 + {7'h0, det_start_o[3]}, c3 + {7'h0, cls_start_o[3]}};
        end
        chk("semi_power", {7'h0, power_on_o[1]}, 8'h00);
        chk("semi_det", {7'h0, n1 != 8'h0}, 8'h01);
        chk("auto_retry", {7'h0, n3 >= 8'h5}, 8'h01);
        chk("auto_nocls", c3, 8'h00);
        chk("man_idle", n2, 8'h00);
        rd(A_DET_RES, d); chk("det_res", d & 8'h0A, 8'h02);
        wr(A_PWR_EN, 8'h02); chk("semi_on", {7'h0, power_on_o[1]}, 8'h01);
        wr(A_CLS_CMD, 8'h04);
        n2 = 8'h0;
        for (int i = 0; i < 20 && n2 == 8'h0; i++) begin
            @(negedge ref_clk_i);
            if (port_reset_o[2] === 1'b1) n2 = 8'h1;
        end
        chk("man_reset", n2, 8'h01);
        if (n2 == 8'h0) stop_test();
        wr(A_PWR_EN, 8'h04); chk("man_on", {7'h0, power_on_o[2]}, 8'h01);
        rd(A_ASG_CLS, d); chk("asg_semi", {4'h0, d[7:4]}, 8'h01);
        rd(A_ASG_CLS + 8'h1, d); chk("asg_man", {4'h0, d[3:0]}, 8'h00);
        $display("test modes done");
        mps_ok_i[1] = 1'b0;
        repeat (MPS_TB - 1) @(negedge ref_clk_i);
        chk("mps_hold", {7'h0, power_on_o[1]}, 8'h01);
        repeat (3) @(negedge ref_clk_i);
        chk("mps_off", {7'h0, power_on_o[1]}, 8'h00);
        fault_i[2] = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        chk("fault_off", {7'h0, power_on_o[2]}, 8'h00);
        $display("test shutdown done");
        chk("police_rst", policing_o[7:0], POLICE_RST);
        wr(A_POLICE, 8'h5A);
        rd(A_POLICE, d); chk("police_rd", d, 8'h5A);
        chk("police_out", policing_o[7:0], 8'h5A);
        wr(A_MODE_LO, 8'h00);
        @(negedge ref_clk_i);
        chk("all_off", power_on_o, 8'h00);
        rd(A_DET_RES, d); chk("det_clr", d, 8'h00);
        $display("test policing and off done");
        ce_i = 1'b0;
        wr(A_POLICE, 8'hA5);
        ce_i = 1'b1;
        rd(A_POLICE, d); chk("ce_frozen", d, 8'h5A);
        $display("test clock enable done");
        stop_test();
    end
endmodule
